// ### hw/sapie_defines.vh
// Purpose: constants for the Sa6 pattern interrupt enable block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef SAPIE_DEFINES_VH
`define SAPIE_DEFINES_VH

// Register byte offsets
`define SAPIE_ENABLE_OFS      12'h000
`define SAPIE_STATUS_OFS      12'h004
`define SAPIE_MASK_OFS        12'h008
`define SAPIE_CODE_OFS        12'h00C

// Enable, status and mask bit positions
`define SAPIE_BIT_ZERO        0
`define SAPIE_BIT_OTHER       1
`define SAPIE_BIT_2X          2
`define SAPIE_BIT_8           3
`define SAPIE_BIT_A           4
`define SAPIE_NBITS           5

// Reset values
`define SAPIE_ENABLE_RST      5'h00
`define SAPIE_MASK_RST        5'h00

// Monitored Sa6 codes and the reset code
`define SAPIE_CODE_A          4'hA
`define SAPIE_CODE_8          4'h8
`define SAPIE_CODE_2X         3'h1
`define SAPIE_CODE_ZERO       4'h0
`define SAPIE_CODE_RST        4'h0

`endif

// ### hw/sapie_detect.v
// Purpose: classify a debounced Sa6 code and flag pattern changes
// Assumes: code and its strobe come from logic on the same clock
// Notes:   one-cycle event pulses, one per pattern class
`timescale 1ns/1ps
`include "sapie_defines.vh"

module sapie_detect (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    input  wire       clk_en,
    // Debounced code
    input  wire [3:0] sa6_code,
    input  wire       sa6_valid,
    // Events and current class
    output reg  [4:0] event_pulse,
    output reg  [4:0] match_reg
);

    // Class vector: which monitored patterns the code matches
    function [4:0] sapie_class;
        input [3:0] c;
        reg   [4:0] m;
        begin
            m = 5'h00;
            m[`SAPIE_BIT_A]    = (c == `SAPIE_CODE_A);
            m[`SAPIE_BIT_8]    = (c == `SAPIE_CODE_8);
            m[`SAPIE_BIT_2X]   = (c[3:1] == `SAPIE_CODE_2X);
            m[`SAPIE_BIT_ZERO] = (c == `SAPIE_CODE_ZERO);
            // Other: not any explicitly watched code (1111/1110/1100 too)
            m[`SAPIE_BIT_OTHER] = ~(m[`SAPIE_BIT_A] | m[`SAPIE_BIT_8] |
                m[`SAPIE_BIT_2X] | m[`SAPIE_BIT_ZERO] | (c == 4'hF) |
                (c == 4'hE) | (c == 4'hC));
            sapie_class = m;
        end
    endfunction

    wire [4:0] new_class = sapie_class(sa6_code);
    reg  [3:0] code_reg;
    wire       code_change = sa6_valid & (sa6_code != code_reg);

    // Entry and exit of each pattern give a pulse; other on every code change into an other-class code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_reg    <= `SAPIE_CODE_RST;
            match_reg   <= 5'h01;
            event_pulse <= 5'h00;
        end else if (clk_en) begin
            event_pulse <= 5'h00;
            if (code_change) begin
                code_reg  <= sa6_code;
                match_reg <= new_class;
                event_pulse[`SAPIE_BIT_A]    <= new_class[`SAPIE_BIT_A]
                    ^ match_reg[`SAPIE_BIT_A];
                event_pulse[`SAPIE_BIT_8]    <= new_class[`SAPIE_BIT_8]
                    ^ match_reg[`SAPIE_BIT_8];
                event_pulse[`SAPIE_BIT_2X]   <= new_class[`SAPIE_BIT_2X]
                    ^ match_reg[`SAPIE_BIT_2X];
                event_pulse[`SAPIE_BIT_OTHER] <=
                    new_class[`SAPIE_BIT_OTHER];
                event_pulse[`SAPIE_BIT_ZERO] <= new_class[`SAPIE_BIT_ZERO]
                    ^ match_reg[`SAPIE_BIT_ZERO];
            end
        end
    end

endmodule

// ### hw/sapie_top.v
// Purpose: Sa6 pattern interrupt enable, status and request over APB
// Assumes: debounced Sa6 code arrives on pclk from the framer
// Notes:   zero-wait APB slave, status clears on read
`timescale 1ns/1ps
`include "sapie_defines.vh"

module sapie_top (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Debounced Sa6 code from framer
    input  wire [3:0]  sa6_code,
    input  wire        sa6_valid,
    // Interrupt outputs
    output reg  [4:0]  event_irq,
    output reg         irq
);

    reg  [4:0] enable_reg;
    reg  [4:0] status_reg;
    reg  [4:0] mask_reg;
    reg  [4:0] status_next;
    reg  [4:0] enable_next;
    reg  [4:0] mask_next;
    wire [4:0] event_pulse;
    wire [4:0] match_state;

    sapie_detect u_detect (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .sa6_code    (sa6_code),
        .sa6_valid   (sa6_valid),
        .event_pulse (event_pulse),
        .match_reg   (match_state)
    );

    // Known register offsets
    function addr_known;
        input [11:0] a;
        begin
            addr_known = (a == `SAPIE_ENABLE_OFS) |
                (a == `SAPIE_STATUS_OFS) | (a == `SAPIE_MASK_OFS) |
                (a == `SAPIE_CODE_OFS);
        end
    endfunction

    // Setup phase decides; access phase completes in one cycle
    wire setup  = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_en  = access & pwrite;
    wire rd_st  = access & ~pwrite & (paddr == `SAPIE_STATUS_OFS);

    // Set wins over the read clear so no event is lost
    always @* begin
        status_next = status_reg;
        if (rd_st)
            status_next = 5'h00;
        status_next = status_next | (event_pulse & enable_reg);
    end

    // Next enable and mask, so requests follow a write at the same edge
    always @* begin
        enable_next = enable_reg;
        mask_next   = mask_reg;
        if (wr_en && paddr == `SAPIE_ENABLE_OFS)
            enable_next = pwdata[4:0];
        if (wr_en && paddr == `SAPIE_MASK_OFS)
            mask_next = pwdata[4:0];
    end

    // Register file
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= `SAPIE_ENABLE_RST;
            mask_reg   <= `SAPIE_MASK_RST;
            status_reg <= 5'h00;
        end else if (clk_en) begin
            status_reg <= status_next;
            enable_reg <= enable_next;
            mask_reg   <= mask_next;
        end
    end

    // APB answer: ready one cycle after setup, data captured at setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup & ~addr_known(paddr);
            prdata  <= 32'h00000000;
            if (setup && !pwrite) begin
                case (paddr)
                    `SAPIE_ENABLE_OFS: prdata <= {27'h0, enable_reg};
                    `SAPIE_STATUS_OFS: prdata <= {27'h0, status_next};
                    `SAPIE_MASK_OFS:   prdata <= {27'h0, mask_reg};
                    `SAPIE_CODE_OFS:   prdata <= {27'h0, match_state};
                    default:           prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Requests registered from next state; a disable drops them at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq <= 5'h00;
            irq       <= 1'b0;
        end else if (clk_en) begin
            event_irq <= status_next & enable_next;
            irq       <= |(status_next & enable_next & mask_next);
        end
    end

endmodule

// ### sim/sapie_monitor.sv
// Purpose: APB and interrupt checks on sapie_top
// Assumes: clk_en high whenever an APB transfer runs
// Notes:   bound to every sapie_top
`timescale 1ns/1ps
`include "sapie_defines.vh"
module sapie_monitor (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Sa6 and requests
    input wire [3:0]  sa6_code,
    input wire        sa6_valid,
    input wire [4:0]  event_irq,
    input wire        irq
);
    // Finished status read, the only thing besides enable and mask writes that may drop irq
    wire rd_stat = pready && !pwrite && paddr == `SAPIE_STATUS_OFS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable && clk_en
        |=> pready)
        else $error("pready late");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    unmapped_read_zero_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    enable_upper_zero_a: assert property (pready && !pwrite &&
        paddr == `SAPIE_ENABLE_OFS |-> prdata[31:5] == 27'h0)
        else $error("enable upper bits set");
    irq_needs_event_a: assert property (irq |-> event_irq != 5'h00)
        else $error("irq without request");
    pattern_a_cause_a: assert property ($rose(event_irq[4])
        |-> $past(sa6_valid, 2)) else $error("request without code");
    status_clear_only_a: assert property ($fell(irq) |->
        $past(rd_stat) || $past(rd_stat, 2) || $past(rd_stat, 3))
        else $error("irq dropped without read");
    cover property (event_irq[4]);
    cover property (pslverr);
    cover property ($fell(irq));
    cover property (event_irq[1]);
endmodule
bind sapie_top sapie_monitor mon (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .sa6_code  (sa6_code),
    .sa6_valid (sa6_valid),
    .event_irq (event_irq),
    .irq       (irq)
);

// ### sim/test_sapie_top.sv
// Purpose: register and event sequences for sapie_top
// Assumes: zero-wait APB slave
// Notes:   code table holds expected status per step
`timescale 1ns/1ps
`include "sapie_defines.vh"
module test_sapie_top;
    reg pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    reg pwrite = 0, sa6_valid = 0, err;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, q;
    reg [3:0] sa6_code = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [4:0] event_irq;
    integer mismatches = 0, checked = 0, i;
    // Codes A,8,3,2,5,0,F from reset code 0 and the status each leaves
    reg [27:0] codes = 28'hA83250F;
    reg [55:0] exps = 56'h11180C00060101;
    sapie_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sa6_code(sa6_code), .sa6_valid(sa6_valid),
        .event_irq(event_irq), .irq(irq));
    // Clock
    always #12.5 pclk = ~pclk;
    task conclude;
        begin
            $display("mismatches %0d checked %0d", mismatches, checked);
            if (mismatches == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0t saw %h want %h", $time, s, e);
            end
        end
    endtask
    // One APB transfer; data taken and request dropped at the pready edge
    task xfer(input [11:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1;
            penable <= 0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            @(posedge pclk);
            // Read right after the edge: values as the slave left them
            for (n = 0; !pready && n < 20; n = n + 1)
                @(posedge pclk);
            if (!pready) begin
                mismatches = mismatches + 1;
                conclude;
            end else begin
                q = prdata;
                err = pslverr;
                psel <= 0;
                penable <= 0;
            end
        end
    endtask
    // One valid code, then time for status and requests to settle
    task send(input [3:0] c);
        begin
            @(posedge pclk);
            sa6_code <= c; sa6_valid <= 1;
            @(posedge pclk);
            sa6_valid <= 0;
            repeat (4) @(posedge pclk);
            #1;
        end
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        xfer(`SAPIE_ENABLE_OFS, 0, 0);
        chk(q, 0);
        xfer(`SAPIE_ENABLE_OFS, 1, 32'h1F);
        xfer(`SAPIE_ENABLE_OFS, 0, 0);
        chk(q, 32'h1F);
        xfer(`SAPIE_MASK_OFS, 1, 32'h1F);
        xfer(`SAPIE_MASK_OFS, 0, 0);
        chk(q, 32'h1F);
        for (i = 0; i < 7; i = i + 1) begin
            send(codes[4*(6-i)+:4]);
            chk(event_irq, exps[8*(6-i)+:5]);
            chk(irq, exps[8*(6-i)+:5] != 0);
            xfer(`SAPIE_STATUS_OFS, 0, 0);
            chk(q, exps[8*(6-i)+:5]);
        end
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 0);
        // Disabled event is not latched
        xfer(`SAPIE_ENABLE_OFS, 1, 0);
        send(4'h0);
        xfer(`SAPIE_ENABLE_OFS, 1, 32'h1F);
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 0);
        // Unmapped offset is refused and reads zero
        xfer(12'h010, 0, 0);
        chk(q, 0);
        chk(err, 1);
        // Mask holds irq low but not the request
        xfer(`SAPIE_MASK_OFS, 1, 0);
        send(4'hA);
        chk(irq, 0);
        chk(event_irq, 5'h11);
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 32'h11);
        // Every entry into an unmonitored code other than F, E or C sets the other flag again
        send(4'h5);
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 32'h12);
        send(4'h6);
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 32'h02);
        xfer(`SAPIE_CODE_OFS, 0, 0);
        chk(q, 32'h02);
        // A strobe seen while the clock enable is low is lost
        clk_en <= 0;
        send(4'hA);
        clk_en <= 1;
        xfer(`SAPIE_STATUS_OFS, 0, 0);
        chk(q, 0);
        xfer(`SAPIE_CODE_OFS, 0, 0);
        chk(q, 32'h02);
        conclude;
    end
endmodule
